// *** core/ptr_top.sv ***
// pointer interpreter top: classifier, state machine, register file
// assumes words valid while frame_strobe pulses, same clock
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ptr_map.svh"
module ptr_top
    import ptr_pkg::*;
#(
    parameter int AIS_FRAMES  = `PTR_AIS_FRAMES,
    parameter int STEADY_STATE_FRAMES = `PTR_STEADY_STATE_FRAMES,
    parameter int LOSS_FRAMES = `PTR_LOSS_FRAMES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        frame_strobe,
    input  wire logic [15:0] primary_word,
    input  wire logic [15:0] concat_word,
    output logic [9:0]       cur_pointer,
    output ptr_cc_t          concat_class,
    output logic             irq_line_a,
    output logic             irq_line_b
);
    if (AIS_FRAMES < 1 || AIS_FRAMES > 15)
        $error("AIS_FRAMES out of range");
    if (STEADY_STATE_FRAMES < 1 || STEADY_STATE_FRAMES > 15)
        $error("STEADY_STATE_FRAMES out of range");
    if (LOSS_FRAMES < 1 || LOSS_FRAMES > 15)
        $error("LOSS_FRAMES out of range");

    ptr_cls_if   cls ();
    ptr_state_t  state;
    ptr_state_t  next_state;
    logic [3:0]  ais_cnt;
    logic [3:0]  steady_state_cnt;
    logic [3:0]  inv_cnt;
    logic [1:0]  inhibit;
    logic [9:0]  cand;
    logic [9:0]  next_cur;
    logic [9:0]  val;
    logic        sdh;
    logic        take_ais;
    logic        take_ndf;
    logic        take_steady_state;
    logic        take_inc;
    logic        take_dec;
    logic        ptr_valid;
    logic [1:0]  evt;
    logic [1:0]  now;

    // classifier hookup, word layout
    assign val = primary_word[9:0];
    assign cls.word = primary_word;
    assign cls.cword = concat_word;
    assign cls.cur = cur_pointer;
    assign cls.sdh = sdh;

    ptr_classify u_cls (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (cls.cls)
    );

    // per-frame decisions
    assign take_ais = cls.is_ais && ais_cnt == 4'(AIS_FRAMES - 1)
        && state != alarm_signal_state;
    assign take_ndf = cls.ndf_ok && state != pointer_lost_state;
    assign take_steady_state = cls.steady_state_ok && (steady_state_cnt == 4'(STEADY_STATE_FRAMES - 1))
        && val == cand;
    assign take_inc = state == steady_state && inhibit == 2'h0
        && cls.inc && !cls.dec;
    assign take_dec = state == steady_state && inhibit == 2'h0
        && cls.dec && !cls.inc;

    // valid pointer per state for loss counting
    always_comb
    begin
        ptr_valid = 1'b0;
        case (state)
            alarm_signal_state:
                ptr_valid = cls.is_ais;
            steady_state:
                ptr_valid = cls.ndf_ok || cls.inc || cls.dec
                    || (cls.steady_state_ok && val == cur_pointer);
            default:
                ptr_valid = 1'b1;
        endcase
    end

    // next state and pointer
    always_comb
    begin
        next_state = state;
        next_cur = cur_pointer;
        if (take_ais)
            next_state = alarm_signal_state;
        else if (take_ndf)
        begin
            next_state = steady_state;
            next_cur = val;
        end
        else if (take_steady_state)
        begin
            next_state = steady_state;
            next_cur = val;
        end
        else if (take_inc)
            next_cur = cur_pointer == `PTR_VAL_MAX ? `PTR_VAL_RESET
                : cur_pointer + 10'h001;
        else if (take_dec)
            next_cur = cur_pointer == `PTR_VAL_RESET ? `PTR_VAL_MAX
                : cur_pointer - 10'h001;
        else if (!ptr_valid && inv_cnt == 4'(LOSS_FRAMES - 1)
            && state != pointer_lost_state)
            next_state = pointer_lost_state;
    end

    // state and pointer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= pointer_lost_state;
            cur_pointer <= `PTR_VAL_RESET;
        end
        else if (frame_strobe)
        begin
            state <= next_state;
            cur_pointer <= next_cur;
        end
    end

    // concatenation class capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            concat_class <= cc_normal;
        else if (frame_strobe)
            concat_class <= cls.cclass;
    end

    // alarm word persistence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ais_cnt <= 4'h0;
        else if (frame_strobe)
        begin
            if (!cls.is_ais || take_ais)
                ais_cnt <= 4'h0;
            else if (ais_cnt != 4'hF)
                ais_cnt <= ais_cnt + 4'h1;
        end
    end

    // equal normal pointer persistence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            steady_state_cnt <= 4'h0;
            cand <= `PTR_VAL_RESET;
        end
        else if (frame_strobe)
        begin
            if (!cls.steady_state_ok || take_steady_state)
                steady_state_cnt <= 4'h0;
            else if (val != cand || steady_state_cnt == 4'h0)
            begin
                steady_state_cnt <= 4'h1;
                cand <= val;
            end
            else if (steady_state_cnt != 4'hF)
                steady_state_cnt <= steady_state_cnt + 4'h1;
        end
    end

    // invalid pointer persistence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inv_cnt <= 4'h0;
        else if (frame_strobe)
        begin
            if (ptr_valid || next_state != state)
                inv_cnt <= 4'h0;
            else if (inv_cnt != 4'hF)
                inv_cnt <= inv_cnt + 4'h1;
        end
    end

    // justification inhibit window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inhibit <= 2'h0;
        else if (frame_strobe)
        begin
            if (take_ndf || take_inc || take_dec)
                inhibit <= `PTR_INH_FRAMES;
            else if (inhibit != 2'h0)
                inhibit <= inhibit - 2'h1;
        end
    end

    // state change events to the register file
    assign now[`PTR_BIT_ALARM] = state == alarm_signal_state;
    assign now[`PTR_BIT_LOSS] = state == pointer_lost_state;
    assign evt[`PTR_BIT_ALARM] = frame_strobe
        && ((next_state == alarm_signal_state) != now[`PTR_BIT_ALARM]);
    assign evt[`PTR_BIT_LOSS] = frame_strobe
        && ((next_state == pointer_lost_state) != now[`PTR_BIT_LOSS]);

    ptr_regs u_regs (
        .pclk       (pclk),
        .presetn    (presetn),
        .paddr      (paddr),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .evt        (evt),
        .now        (now),
        .cur        (cur_pointer),
        .cclass     (concat_class),
        .sdh        (sdh),
        .irq_line_a (irq_line_a),
        .irq_line_b (irq_line_b)
    );

    // checks on the state machine
    property p_onehot;
        @(posedge pclk) disable iff (!presetn)
        $onehot({state == steady_state, state == pointer_lost_state,
            state == alarm_signal_state});
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not exclusive");

    property p_ais_entry;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && cls.is_ais && ais_cnt == 4'(AIS_FRAMES - 1)
            && state != alarm_signal_state |=> state == alarm_signal_state;
    endproperty
    a_ais_entry: assert property (p_ais_entry) else $error("alarm not entered");

    property p_loss_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(state == pointer_lost_state)
            |-> $past(inv_cnt) == 4'(LOSS_FRAMES - 1);
    endproperty
    a_loss_cause: assert property (p_loss_cause) else $error("early loss");

    property p_ndf;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && take_ndf && !take_ais
            |=> state == steady_state && cur_pointer == $past(val);
    endproperty
    a_ndf: assert property (p_ndf) else $error("new location ignored");

    property p_norm3;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && take_steady_state && !take_ais && !take_ndf
            |=> state == steady_state && cur_pointer == $past(val);
    endproperty
    a_norm3: assert property (p_norm3) else $error("normal pointer ignored");

    sequence s_hold_ptr;
        cur_pointer == $past(cur_pointer);
    endsequence
    property p_inhibit;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && inhibit != 2'h0 && !cls.ndf_ok && !take_steady_state
            |=> s_hold_ptr;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("justified in window");

    property p_inc;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && take_inc && !take_ais && !take_ndf && !take_steady_state
            && cur_pointer != `PTR_VAL_MAX
            |=> cur_pointer == $past(cur_pointer) + 10'h001
                && state == steady_state;
    endproperty
    a_inc: assert property (p_inc) else $error("increment not applied");

    property p_equal_valid;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && state == steady_state && cls.steady_state_ok
            && val == cur_pointer && !take_ais |=> inv_cnt == 4'h0;
    endproperty
    a_equal_valid: assert property (p_equal_valid) else $error("equal counted");

    property p_dec;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && take_dec && !take_ais && !take_ndf && !take_steady_state
            && cur_pointer != `PTR_VAL_RESET
            |=> cur_pointer == $past(cur_pointer) - 10'h001
                && state == steady_state;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement not applied");

    property p_alarm_valid;
        @(posedge pclk) disable iff (!presetn)
        frame_strobe && state == alarm_signal_state && cls.is_ais |=> inv_cnt == 4'h0;
    endproperty
    a_alarm_valid: assert property (p_alarm_valid) else $error("alarm word counted");
endmodule : ptr_top

// *** core/ptr_map.svh ***
// constants of the pointer interpreter
// assumes inclusion by every file that needs numbers
`ifndef PTR_MAP_SVH
`define PTR_MAP_SVH
`define PTR_REG_CTRL    8'h00
`define PTR_REG_STAT    8'h04
`define PTR_REG_PEND    8'h08
`define PTR_REG_MASKA   8'h0C
`define PTR_REG_MASKB   8'h10
`define PTR_REG_PTR     8'h14
`define PTR_BIT_ALARM   0
`define PTR_BIT_LOSS    1
`define PTR_BIT_SDH     0
`define PTR_FLAG_NDF    4'h9
`define PTR_FLAG_STEADY_STATE   4'h6
`define PTR_SS_SDH      2'h2
`define PTR_VAL_MAX     10'h30E
`define PTR_VAL_ONES    10'h3FF
`define PTR_VAL_RESET   10'h000
`define PTR_AIS_WORD    16'hFFFF
`define PTR_I_MASK      10'h2AA
`define PTR_D_MASK      10'h155
`define PTR_FLAG_MIN    3'h3
`define PTR_SONET_MIN   4'h8
`define PTR_SDH_MIN     4'h3
`define PTR_SDH_MAX     4'h2
`define PTR_AIS_FRAMES  3
`define PTR_STEADY_STATE_FRAMES 3
`define PTR_LOSS_FRAMES 8
`define PTR_INH_FRAMES  2'h3
`endif

// *** core/ptr_pkg.sv ***
// types of the pointer interpreter
// assumes nothing beyond the compile order
package ptr_pkg;
    typedef enum logic [1:0] {steady_state, pointer_lost_state,
        alarm_signal_state} ptr_state_t;
    typedef enum logic [1:0] {cc_normal, cc_alarm,
        cc_invalid} ptr_cc_t;
endpackage : ptr_pkg

// *** core/ptr_cls_if.sv ***
// classifier request and result bundle
// assumes one clock domain, all signals combinational
`timescale 1ns/1ps
interface ptr_cls_if;
    import ptr_pkg::*;
    logic [15:0] word;
    logic [15:0] cword;
    logic [9:0]  cur;
    logic        sdh;
    logic        ndf_ok;
    logic        steady_state_ok;
    logic        is_ais;
    logic        inc;
    logic        dec;
    ptr_cc_t     cclass;
    modport cls (input word, cword, cur, sdh,
        output ndf_ok, steady_state_ok, is_ais, inc, dec, cclass);
    modport core (output word, cword, cur, sdh,
        input ndf_ok, steady_state_ok, is_ais, inc, dec, cclass);
endinterface : ptr_cls_if

// *** core/ptr_classify.sv ***
// word classifier for primary pointer and concatenation word
// assumes words held stable by the core while it samples them
`timescale 1ns/1ps
`include "ptr_map.svh"
module ptr_classify
    import ptr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ptr_cls_if.cls   c
);
    function automatic logic [3:0] ptr_ones(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 10; i++)
            n = n + {3'h0, v[i]};
        return n;
    endfunction : ptr_ones

    logic [3:0] fl_ndf;
    logic [3:0] fl_steady_state;
    logic [3:0] cf_ndf;
    logic [9:0] diff;
    logic [3:0] inv_i;
    logic [3:0] inv_d;
    logic       ss_ok;
    logic       css_ok;
    logic       steady_state_fl;
    logic       in_rng;
    logic       inc_raw;
    logic       dec_raw;

    // flag majority, three of four
    assign fl_ndf  = ptr_ones({6'h0, ~(c.word[15:12] ^ `PTR_FLAG_NDF)});
    assign fl_steady_state = ptr_ones({6'h0, ~(c.word[15:12] ^ `PTR_FLAG_STEADY_STATE)});
    assign cf_ndf  = ptr_ones({6'h0, ~(c.cword[15:12] ^ `PTR_FLAG_NDF)});
    assign ss_ok   = !c.sdh || (c.word[11:10] == `PTR_SS_SDH);
    assign css_ok  = !c.sdh || (c.cword[11:10] == `PTR_SS_SDH);
    assign in_rng  = c.word[9:0] <= `PTR_VAL_MAX;
    assign c.is_ais = c.word == `PTR_AIS_WORD;
    assign c.ndf_ok = (fl_ndf[2:0] >= `PTR_FLAG_MIN || fl_ndf[3]) && in_rng && ss_ok;
    assign steady_state_fl = (fl_steady_state[2:0] >= `PTR_FLAG_MIN || fl_steady_state[3]) && ss_ok;
    assign c.steady_state_ok = steady_state_fl && in_rng;

    // justification majority per mode
    assign diff  = c.word[9:0] ^ c.cur;
    assign inv_i = ptr_ones(diff & `PTR_I_MASK);
    assign inv_d = ptr_ones(diff & `PTR_D_MASK);
    always_comb
    begin
        if (c.sdh)
        begin
            inc_raw = inv_i >= `PTR_SDH_MIN && inv_d <= `PTR_SDH_MAX;
            dec_raw = inv_d >= `PTR_SDH_MIN && inv_i <= `PTR_SDH_MAX;
        end
        else
        begin
            inc_raw = ptr_ones(~(diff ^ `PTR_I_MASK)) >= `PTR_SONET_MIN;
            dec_raw = ptr_ones(~(diff ^ `PTR_D_MASK)) >= `PTR_SONET_MIN;
        end
    end
    // justification words need no range check, inverted bits may leave it
    assign c.inc = inc_raw && steady_state_fl;
    assign c.dec = dec_raw && steady_state_fl;

    // concatenation word class
    always_comb
    begin
        if (c.cword == `PTR_AIS_WORD)
            c.cclass = cc_alarm;
        else if ((cf_ndf[2:0] >= `PTR_FLAG_MIN || cf_ndf[3])
            && c.cword[9:0] == `PTR_VAL_ONES && css_ok)
            c.cclass = cc_normal;
        else
            c.cclass = cc_invalid;
    end

    property p_sdh_none;
        @(posedge pclk) disable iff (!presetn)
        c.sdh && inv_i >= `PTR_SDH_MIN && inv_d >= `PTR_SDH_MIN |-> !c.inc && !c.dec;
    endproperty
    a_sdh_none: assert property (p_sdh_none) else $error("sdh both inverted acted");
endmodule : ptr_classify

// *** core/ptr_regs.sv ***
// apb register file with latches, pending bits and irq routing
// assumes events are one-cycle pulses on pclk
`timescale 1ns/1ps
`include "ptr_map.svh"
module ptr_regs
    import ptr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  evt,
    input  wire logic [1:0]  now,
    input  wire logic [9:0]  cur,
    input  wire ptr_cc_t     cclass,
    output logic             sdh,
    output logic             irq_line_a,
    output logic             irq_line_b
);
    logic [1:0]  latch;
    logic [1:0]  pend;
    logic [1:0]  mask_a;
    logic [1:0]  mask_b;
    logic        rd;
    logic        wr;
    logic        hit;
    logic [31:0] rval;

    assign rd = psel && !penable && !pwrite;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;

    // address decode
    always_comb
    begin
        hit = 1'b1;
        rval = 32'h0;
        if (paddr == `PTR_REG_CTRL)
            rval = {31'h0, sdh};
        else if (paddr == `PTR_REG_STAT)
            rval = {30'h0, latch | now};
        else if (paddr == `PTR_REG_PEND)
            rval = {30'h0, pend};
        else if (paddr == `PTR_REG_MASKA)
            rval = {30'h0, mask_a};
        else if (paddr == `PTR_REG_MASKB)
            rval = {30'h0, mask_b};
        else if (paddr == `PTR_REG_PTR)
            rval = {18'h0, cclass, now, cur};
        else
            hit = 1'b0;
    end
    assign pslverr = psel && penable && !hit;

    // read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd)
            prdata <= rval;
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sdh <= 1'b0;
            mask_a <= 2'h0;
            mask_b <= 2'h0;
        end
        else if (wr && paddr == `PTR_REG_CTRL)
            sdh <= pwdata[`PTR_BIT_SDH];
        else if (wr && paddr == `PTR_REG_MASKA)
            mask_a <= pwdata[1:0];
        else if (wr && paddr == `PTR_REG_MASKB)
            mask_b <= pwdata[1:0];
    end

    // latch-high and pending, set wins over read clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch <= 2'h0;
            pend <= 2'h0;
        end
        else
        begin
            latch <= (rd && paddr == `PTR_REG_STAT ? 2'h0 : latch) | evt;
            pend <= (rd && paddr == `PTR_REG_PEND ? 2'h0 : pend) | evt;
        end
    end

    // mask routing onto two lines
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_line_a <= 1'b0;
            irq_line_b <= 1'b0;
        end
        else
        begin
            irq_line_a <= |(pend & mask_a);
            irq_line_b <= |(pend & mask_b);
        end
    end

    property p_pend_set;
        @(posedge pclk) disable iff (!presetn)
        evt[`PTR_BIT_ALARM] |=> pend[`PTR_BIT_ALARM] ##1 (irq_line_a || !mask_a[0]);
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("alarm pending lost");
    property p_loss_latch;
        @(posedge pclk) disable iff (!presetn)
        evt[`PTR_BIT_LOSS] |=> latch[`PTR_BIT_LOSS];
    endproperty
    a_loss_latch: assert property (p_loss_latch) else $error("loss latch lost");
    property p_pend_clr;
        @(posedge pclk) disable iff (!presetn)
        rd && paddr == `PTR_REG_PEND && evt == 2'h0 |=> pend == 2'h0;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
endmodule : ptr_regs

// *** verification/ptr_far_end.sv ***
// far end model: one framed pointer pair per bench request
// assumes requests from the bench, changed after pclk edges
`timescale 1ns/1ps
module ptr_far_end
(
    input  wire logic        pclk,
    input  wire logic        req,
    input  wire logic [15:0] pri,
    input  wire logic [15:0] con,
    output logic             frame_strobe,
    output logic [15:0]      primary_word,
    output logic [15:0]      concat_word
);
    // words valid with the strobe only, scrambled in between
    always_ff @(posedge pclk)
    begin
        frame_strobe <= req;
        primary_word <= req ? {pri[15:8], pri[7:0]} : ~primary_word;
        concat_word  <= req ? con : ~concat_word;
    end
endmodule : ptr_far_end

// *** verification/ptr_top_test.sv ***
// self-checking bench of the pointer interpreter
// assumes ptr_top, its package and the far end model
`timescale 1ns/1ps
`include "ptr_map.svh"
module ptr_top_test;
    import ptr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        req, frame_strobe, irq_line_a, irq_line_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] pri, con, primary_word, concat_word;
    logic [9:0]  cur_pointer, e;
    ptr_cc_t     concat_class;
    int          n_errors, samples_checked, cycles, seed;
    logic [15:0] cw [4] = '{16'h9BFF, 16'hBBFF, 16'hFFFF, 16'h9BFE};
    ptr_cc_t     cc [4] = '{cc_normal, cc_normal, cc_alarm, cc_invalid};

    ptr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
        .primary_word(primary_word), .concat_word(concat_word),
        .cur_pointer(cur_pointer), .concat_class(concat_class),
        .irq_line_a(irq_line_a), .irq_line_b(irq_line_b));
    ptr_far_end far (.pclk(pclk), .req(req), .pri(pri), .con(con),
        .frame_strobe(frame_strobe), .primary_word(primary_word),
        .concat_word(concat_word));

    // 25 MHz clock
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // pointer word with size bits 10
    function automatic logic [15:0] nw(input logic [3:0] f, input logic [9:0] v);
        return {f, 2'h2, v};
    endfunction : nw

    // one justification step with wrap
    function automatic logic [9:0] step(input logic [9:0] v, input logic up);
        if (up)
            return (v == `PTR_VAL_MAX) ? 10'h000 : v + 10'h001;
        return (v == 10'h000) ? `PTR_VAL_MAX : v - 10'h001;
    endfunction : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_irq(input logic a, input logic b);
        chk({irq_line_a, irq_line_b}, {a, b});
    endtask : chk_irq

    // apb transfer, read data left in r, error flag in err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // one frame, then wait for the answer to settle
    task automatic frame(input logic [15:0] p, input logic [15:0] c);
        @(posedge pclk);
        req <= 1'b1;
        pri <= p;
        con <= c;
        @(posedge pclk);
        req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : frame

    task automatic nf(input int n, input logic [9:0] v);
        repeat (n) frame(nw(4'h6, v), 16'h9BFF);
    endtask : nf

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict;
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, req} = 5'h00;
        {paddr, pwdata, pri, con} = 72'h0;
        seed = 50377;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PTR_REG_PTR);
        chk(r[11:0], 32'h800);
        rd(`PTR_REG_CTRL);
        chk(r, 32'h0);
        apb(1'b1, `PTR_REG_MASKA, 32'h3);
        e = 10'($unsigned($random(seed)) % 783);
        nf(2, e);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h2);
        nf(1, e);
        chk(cur_pointer, e);
        chk_irq(1'b1, 1'b0);
        rd(`PTR_REG_STAT);
        chk(r[1:0], 32'h2);
        rd(`PTR_REG_STAT);
        chk(r[1:0], 32'h0);
        rd(`PTR_REG_PEND);
        chk(r[1:0], 32'h2);
        rd(`PTR_REG_PEND);
        chk(r[1:0], 32'h0);
        chk_irq(1'b0, 1'b0);
        $display("test acquire done");
        nf(1, e ^ 10'h2AF);
        e = step(e, 1'b1);
        chk(cur_pointer, e);
        nf(1, e ^ 10'h155);
        chk(cur_pointer, e);
        nf(2, e);
        nf(1, e ^ 10'h155);
        e = step(e, 1'b0);
        chk(cur_pointer, e);
        for (int i = 0; i < 4; i++)
        begin
            nf(0, e);
            frame(nw(4'h6, e), cw[i]);
            chk(concat_class, cc[i]);
        end
        $display("test sonet done");
        apb(1'b1, `PTR_REG_CTRL, 32'h1);
        frame(nw(4'h6, e), 16'h97FF);
        chk(concat_class, cc_invalid);
        nf(2, e);
        nf(1, e ^ 10'h2A5);
        e = step(e, 1'b1);
        chk(cur_pointer, e);
        nf(3, e);
        nf(1, e ^ 10'h15A);
        e = step(e, 1'b0);
        chk(cur_pointer, e);
        nf(3, e);
        nf(1, e ^ 10'h3FF);
        chk(cur_pointer, e);
        apb(1'b1, `PTR_REG_CTRL, 32'h0);
        $display("test sdh done");
        apb(1'b1, `PTR_REG_MASKA, 32'h0);
        apb(1'b1, `PTR_REG_MASKB, 32'h3);
        repeat (2) frame(16'hFFFF, 16'hFFFF);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h0);
        frame(16'hFFFF, 16'hFFFF);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h1);
        chk_irq(1'b0, 1'b1);
        frame(16'hFFFF, 16'hFFFF);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h1);
        rd(`PTR_REG_STAT);
        rd(`PTR_REG_PEND);
        e = 10'($unsigned($random(seed)) % 783);
        frame(nw(4'h9, e), 16'h9BFF);
        chk(cur_pointer, e);
        rd(`PTR_REG_STAT);
        chk(r[1:0], 32'h1);
        rd(`PTR_REG_STAT);
        chk(r[1:0], 32'h0);
        rd(`PTR_REG_PEND);
        chk(r[1:0], 32'h1);
        $display("test alarm done");
        repeat (7) frame(16'h9BFF, 16'h9BFF);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h0);
        frame(16'h9BFF, 16'h9BFF);
        rd(`PTR_REG_PTR);
        chk(r[11:10], 32'h2);
        rd(8'h40);
        chk({30'h0, err, pready}, 32'h3);
        chk(r, 32'h0);
        $display("test loss done");
        print_verdict;
    end
endmodule : ptr_top_test
